// ===== src/dsp_pkg.sv
// constants, types and encodings shared by the audio processing core
`default_nettype none
package dsp_pkg;
  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int WORD_W      = 28;
  localparam int ACC_W       = 56;
  localparam int IN_W        = 24;
  localparam int OUT_W       = 24;
  localparam int PROG_W      = 40;
  localparam int PARAM_W     = 32;
  localparam int MEM_DEPTH   = 512;
  localparam int MEM_AW      = 9;
  localparam int N_ACC       = 3;
  localparam int FIFO_DEPTH  = 8;
  localparam int SL_SLOTS    = 5;
  localparam logic [10:0] INSTR_PER_FRAME = 11'h400;
  // ---------------------------------------------------------------
  // host address map
  // ---------------------------------------------------------------
  localparam logic [15:0] PARAM_LAST = 16'h01ff;
  localparam logic [15:0] PROG_BASE  = 16'h0400;
  localparam logic [15:0] PROG_LAST  = 16'h05ff;
  localparam logic [8:0]  SL_FIRST   = 9'h001;
  localparam logic [8:0]  SL_TGT     = 9'h006;
  localparam logic [8:0]  SL_CNT     = 9'h007;
  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  localparam int OP_LO    = 36;
  localparam int ACC_LO   = 34;
  localparam int DSEL_LO  = 32;
  localparam int CSEL_LO  = 30;
  localparam int DADDR_LO = 21;
  localparam int PADDR_LO = 12;
  localparam int ROM_AW   = 3;
  // ---------------------------------------------------------------
  // reset values and numeric limits
  // ---------------------------------------------------------------
  localparam logic [8:0]  PC_START = 9'h000;
  localparam logic [27:0] UNITY    = 28'h0800000;
  localparam logic [27:0] W_MAX    = 28'h7ffffff;
  localparam logic [27:0] W_MIN    = 28'h8000000;
  localparam logic [23:0] CLIP_MAX = 24'h7fffff;
  localparam logic [23:0] CLIP_MIN = 24'h800000;
  localparam logic [3:0]  PAD_ZERO = 4'h0;
  // constant table: 0, 1, 0.5, 0.25, -1, 2, max, min
  localparam logic [7:0][27:0] ROM_TABLE = {W_MIN, W_MAX, 28'h1000000, 28'hf800000,
                                            28'h0200000, 28'h0400000, UNITY, 28'h0000000};
  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_MAC = 4'h1, OP_MUL = 4'h2, OP_WRD = 4'h3, OP_WRP = 4'h4,
    OP_OUT = 4'h5, OP_JMP = 4'h6, OP_LDC = 4'h7, OP_JNZ = 4'h8, OP_JTS = 4'h9
  } op_type;
  typedef enum logic [1:0] {SRC_RAM = 2'h0, SRC_ROM = 2'h1, SRC_IN = 2'h2, SRC_ZERO = 2'h3} src_type;
  typedef enum {ST_IDLE, ST_SAFE, ST_FETCH, ST_DECODE, ST_EXEC} st_type;
endpackage : dsp_pkg
`default_nettype wire

// ===== src/dsp_mem.sv
// single-port ram with registered read, and a small valid/ready fifo
`default_nettype none
module dsp_ram #(
  parameter int W     = 32,
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  // clock
  input  wire logic          clk,
  // port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wdata,
  output logic      [W-1:0]  rdata_r
);
  // no reset and no init: contents unknown until written
  logic [W-1:0] mem [DEPTH];
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end
endmodule : dsp_ram

module dsp_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_type;
  fifo_type     r;
  fifo_type     s;
  logic [W-1:0] mem [DEPTH];
  logic         push;
  logic         pop;
  always_comb
  begin
    in_ready  = (r.wp[AW-1:0] != r.rp[AW-1:0]) || (r.wp[AW] == r.rp[AW]);
    out_valid = r.wp != r.rp;
    out_data  = mem[r.rp[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    s         = r;
    if (push)
    begin
      s.wp = r.wp + 1'b1;
    end
    if (pop)
    begin
      s.rp = r.rp + 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= s;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[r.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : dsp_fifo
`default_nettype wire

// ===== src/dsp_core.sv
// audio processing core: sequencer, mac datapath, memories and host port
`default_nettype none
module dsp_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // frame and audio inputs
  input  wire logic        frame_start,
  input  wire logic [23:0] audio_in_l,
  input  wire logic [23:0] audio_in_r,
  // host memory port
  input  wire logic        host_wr_en,
  input  wire logic        host_rd_en,
  input  wire logic        host_addr_load,
  input  wire logic [15:0] host_addr,
  input  wire logic [39:0] host_wdata,
  output logic      [39:0] host_rdata,
  output logic             host_rd_valid,
  // audio output stream
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic             out_chan,
  output logic      [23:0] out_sample,
  // status
  output logic             core_busy
);
  typedef struct packed {
    dsp_pkg::st_type   st;
    logic [8:0]        pc;
    logic [10:0]       icnt;
    logic [8:0]        loop;
    logic [39:0]       ir;
    logic [2:0][55:0]  acc;
    logic [27:0]       in_l;
    logic [27:0]       in_r;
    logic              sl_pend;
    logic [2:0]        sl_idx;
    logic [2:0]        sl_cnt;
    logic [8:0]        sl_tgt;
    logic [4:0][27:0]  sl_data;
    logic [15:0]       haddr;
    logic              rd_pend;
    logic              rd_prog;
    logic              rd_map;
    logic [39:0]       rdata;
    logic              rd_valid;
    logic              ov;
    logic [24:0]       od;
    logic              busy;
  } core_type;

  core_type r;
  core_type s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // product is 10.46, keep 5.23 and saturate
  function automatic logic [27:0] sat28(input logic [55:0] v);
    if (v[55:50] == {6{v[55]}})
    begin
      return v[50:23];
    end
    return v[55] ? dsp_pkg::W_MIN : dsp_pkg::W_MAX;
  endfunction : sat28

  function automatic logic [27:0] sext(input logic [23:0] v);
    return {{4{v[23]}}, v};
  endfunction : sext

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  logic        prog_we;
  logic [8:0]  prog_addr;
  logic [39:0] prog_rdata;
  logic        par_we;
  logic [8:0]  par_addr;
  logic [31:0] par_wdata;
  logic [31:0] par_rdata;
  logic        dat_we;
  logic [8:0]  dat_addr;
  logic [27:0] dat_wdata;
  logic [27:0] dat_rdata;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [24:0] f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [24:0] f_out_data;

  dsp_ram #(.W(dsp_pkg::PROG_W), .DEPTH(dsp_pkg::MEM_DEPTH), .AW(dsp_pkg::MEM_AW)) u_prog (
    .clk     (clk),
    .we      (prog_we),
    .addr    (prog_addr),
    .wdata   (host_wdata),
    .rdata_r (prog_rdata)
  );
  dsp_ram #(.W(dsp_pkg::PARAM_W), .DEPTH(dsp_pkg::MEM_DEPTH), .AW(dsp_pkg::MEM_AW)) u_param (
    .clk     (clk),
    .we      (par_we),
    .addr    (par_addr),
    .wdata   (par_wdata),
    .rdata_r (par_rdata)
  );
  // no host path reaches this one
  dsp_ram #(.W(dsp_pkg::WORD_W), .DEPTH(dsp_pkg::MEM_DEPTH), .AW(dsp_pkg::MEM_AW)) u_data (
    .clk     (clk),
    .we      (dat_we),
    .addr    (dat_addr),
    .wdata   (dat_wdata),
    .rdata_r (dat_rdata)
  );
  dsp_fifo #(.W(25), .DEPTH(dsp_pkg::FIFO_DEPTH), .AW(3)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [15:0]     ea;
  logic            h_par;
  logic            h_prog;
  logic            hw_par;
  logic            hw_prog;
  logic            hr_par;
  logic            hr_prog;
  dsp_pkg::op_type op;
  logic [1:0]      asel;
  logic [27:0]     dop;
  logic [27:0]     cop;
  logic [55:0]     prod;
  logic [27:0]     accw;
  logic [23:0]     clip;
  logic [8:0]      dec_d;
  logic [8:0]      dec_p;
  logic            done;

  always_comb
  begin
    s = r;
    // burst writes and reads walk one address per word, any region
    ea      = host_addr_load ? host_addr : r.haddr;
    h_par   = ea <= dsp_pkg::PARAM_LAST;
    h_prog  = (ea >= dsp_pkg::PROG_BASE) && (ea <= dsp_pkg::PROG_LAST);
    hw_par  = host_wr_en && h_par;
    hw_prog = host_wr_en && h_prog;
    hr_par  = host_rd_en && !host_wr_en && h_par;
    hr_prog = host_rd_en && !host_wr_en && h_prog;
    if (host_wr_en || host_rd_en)
    begin
      s.haddr = ea + 16'h0001;
    end

    op    = dsp_pkg::op_type'(r.ir[39:dsp_pkg::OP_LO]);
    asel  = r.ir[dsp_pkg::ACC_LO +: 2];
    dec_d = prog_rdata[dsp_pkg::DADDR_LO +: 9];
    dec_p = prog_rdata[dsp_pkg::PADDR_LO +: 9];
    case (r.ir[dsp_pkg::DSEL_LO +: 2])
      dsp_pkg::SRC_RAM: dop = dat_rdata;
      dsp_pkg::SRC_ROM: dop = dsp_pkg::ROM_TABLE[r.ir[dsp_pkg::DADDR_LO +: dsp_pkg::ROM_AW]];
      dsp_pkg::SRC_IN:  dop = r.ir[dsp_pkg::DADDR_LO] ? r.in_r : r.in_l;
      default:          dop = '0;
    endcase
    case (r.ir[dsp_pkg::CSEL_LO +: 2])
      dsp_pkg::SRC_RAM: cop = par_rdata[27:0];
      dsp_pkg::SRC_ROM: cop = dsp_pkg::ROM_TABLE[r.ir[dsp_pkg::PADDR_LO +: dsp_pkg::ROM_AW]];
      dsp_pkg::SRC_IN:  cop = r.ir[dsp_pkg::PADDR_LO] ? r.in_r : r.in_l;
      default:          cop = '0;
    endcase
    prod = $signed(dop) * $signed(cop);
    accw = sat28(r.acc[asel]);
    // top four bits saturated away
    clip = (accw[27:23] == {5{accw[27]}}) ? accw[23:0] : (accw[27] ? dsp_pkg::CLIP_MIN : dsp_pkg::CLIP_MAX);

    // host has the ports first, the core takes what is left
    prog_we    = hw_prog;
    prog_addr  = (hw_prog || hr_prog) ? ea[8:0] : r.pc;
    par_we     = hw_par;
    par_addr   = ea[8:0];
    par_wdata  = host_wdata[31:0];
    dat_we     = 1'b0;
    dat_addr   = dec_d;
    dat_wdata  = accw;
    f_in_valid = 1'b0;
    f_in_data  = {r.ir[0], clip};
    done       = 1'b0;

    // safeload staging, copies of writes to the low locations
    if (hw_par && (ea[8:0] >= dsp_pkg::SL_FIRST) && (ea[8:0] < dsp_pkg::SL_TGT))
    begin
      s.sl_data[3'(ea[8:0] - dsp_pkg::SL_FIRST)] = host_wdata[27:0];
    end
    if (hw_par && (ea[8:0] == dsp_pkg::SL_TGT))
    begin
      s.sl_tgt = host_wdata[8:0];
    end

    // host reads answer two cycles later
    s.rd_valid = 1'b0;
    if (r.rd_pend)
    begin
      s.rd_valid = 1'b1;
      s.rdata    = !r.rd_map ? '0 : (r.rd_prog ? prog_rdata : {8'h00, par_rdata});
    end
    s.rd_pend = host_rd_en && !host_wr_en;
    s.rd_prog = hr_prog;
    s.rd_map  = hr_par || hr_prog;

    case (r.st)
      dsp_pkg::ST_SAFE:
      begin
        if (!(hw_par || hr_par))
        begin
          // offset of +1 on the stored target
          par_we    = 1'b1;
          par_addr  = r.sl_tgt + 9'h001 + 9'(r.sl_idx);
          par_wdata = {dsp_pkg::PAD_ZERO, r.sl_data[r.sl_idx]};
          s.sl_idx  = r.sl_idx + 3'h1;
          if (r.sl_idx + 3'h1 >= r.sl_cnt)
          begin
            s.st = dsp_pkg::ST_FETCH;
          end
        end
      end
      dsp_pkg::ST_FETCH:
      begin
        // wait while the host holds the program port
        if (!(hw_prog || hr_prog))
        begin
          s.st = dsp_pkg::ST_DECODE;
        end
      end
      dsp_pkg::ST_DECODE:
      begin
        s.ir = prog_rdata;
        if (!host_wr_en && !host_rd_en)
        begin
          par_addr = dec_p;
        end
        s.st = dsp_pkg::ST_EXEC;
      end
      dsp_pkg::ST_EXEC:
      begin
        done = 1'b1;
        s.pc = r.pc + 9'h001;
        case (op)
          dsp_pkg::OP_MAC: if (asel < 2'(dsp_pkg::N_ACC)) s.acc[asel] = r.acc[asel] + prod;
          dsp_pkg::OP_MUL: if (asel < 2'(dsp_pkg::N_ACC)) s.acc[asel] = prod;
          dsp_pkg::OP_WRD:
          begin
            dat_we   = 1'b1;
            dat_addr = r.ir[dsp_pkg::DADDR_LO +: 9];
          end
          dsp_pkg::OP_WRP:
          begin
            // dropped if the host holds the port this cycle
            if (!(hw_par || hr_par))
            begin
              par_we    = 1'b1;
              par_addr  = r.ir[dsp_pkg::PADDR_LO +: 9];
              par_wdata = {dsp_pkg::PAD_ZERO, accw};
            end
          end
          dsp_pkg::OP_OUT:
          begin
            f_in_valid = 1'b1;
            // a full fifo stalls the program here
            if (!f_in_ready)
            begin
              done = 1'b0;
              s.pc = r.pc;
            end
          end
          dsp_pkg::OP_JMP: s.pc = r.ir[8:0];
          dsp_pkg::OP_LDC: s.loop = r.ir[8:0];
          dsp_pkg::OP_JNZ:
          begin
            if (r.loop != 9'h000)
            begin
              s.loop = r.loop - 9'h001;
              s.pc   = r.ir[8:0];
            end
          end
          dsp_pkg::OP_JTS:
          begin
            s.pc = dsp_pkg::PC_START;
            s.st = dsp_pkg::ST_IDLE;
          end
          default: s.pc = r.pc + 9'h001;
        endcase
        if (done)
        begin
          s.icnt = r.icnt + 11'h001;
          if (op != dsp_pkg::OP_JTS)
          begin
            // instruction budget for one sample period
            s.st = (r.icnt + 11'h001 >= dsp_pkg::INSTR_PER_FRAME) ? dsp_pkg::ST_IDLE : dsp_pkg::ST_FETCH;
          end
        end
      end
      dsp_pkg::ST_IDLE: s.st = dsp_pkg::ST_IDLE;
      default:          s.st = dsp_pkg::ST_IDLE;
    endcase

    // a new frame restarts the program wherever it stood
    if (frame_start)
    begin
      s.in_l   = sext(audio_in_l);
      s.in_r   = sext(audio_in_r);
      s.pc     = dsp_pkg::PC_START;
      s.icnt   = '0;
      s.sl_idx = '0;
      s.st     = (r.sl_pend && r.sl_cnt != 3'h0) ? dsp_pkg::ST_SAFE : dsp_pkg::ST_FETCH;
      s.sl_pend = 1'b0;
    end
    // set after the clear, so a trigger in the frame cycle survives
    if (hw_par && (ea[8:0] == dsp_pkg::SL_CNT))
    begin
      s.sl_cnt  = (host_wdata[2:0] > 3'(dsp_pkg::SL_SLOTS)) ? 3'(dsp_pkg::SL_SLOTS) : host_wdata[2:0];
      s.sl_pend = 1'b1;
    end

    // output skid register keeps the ports on flops
    f_out_ready = !r.ov || out_ready;
    if (f_out_valid && f_out_ready)
    begin
      s.ov = 1'b1;
      s.od = f_out_data;
    end
    else if (out_ready)
    begin
      s.ov = 1'b0;
    end
    s.busy = s.st != dsp_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r    <= '0;
      r.st <= dsp_pkg::ST_IDLE;
    end
    else
    begin
      r <= s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign host_rdata    = r.rdata;
  assign host_rd_valid = r.rd_valid;
  assign out_valid     = r.ov;
  assign out_chan      = r.od[24];
  assign out_sample    = r.od[23:0];
  assign core_busy     = r.busy;
endmodule : dsp_core
`default_nettype wire

// ===== test/dsp_core_props.sv
// port assertions for the audio processing core
`default_nettype none
module dsp_core_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // host and frame side
  input wire logic        frame_start,
  input wire logic        host_wr_en,
  input wire logic        host_rd_en,
  input wire logic        host_addr_load,
  input wire logic [15:0] host_addr,
  input wire logic [39:0] host_rdata,
  input wire logic        host_rd_valid,
  // stream and status
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        out_chan,
  input wire logic [23:0] out_sample,
  input wire logic        core_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // 3 cycles per instruction plus safeload and margin
  localparam logic [12:0] RUN_MAX = 13'h0c15;
  logic        rd_go;
  logic        unmapped;
  logic [12:0] run_r;
  logic [12:0] run_nxt;
  assign rd_go    = host_rd_en && !host_wr_en;
  assign unmapped = host_addr > 16'h05ff || (host_addr > 16'h01ff && host_addr < 16'h0400);
  // cycles with a stream word held unaccepted at the port are not counted against the budget
  assign run_nxt  = frame_start ? 13'h0000 : (core_busy && !(out_valid && !out_ready)) ? run_r + 13'h0001 : run_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_r <= 13'h0000;
    else
      run_r <= run_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd_go |-> ##2 host_rd_valid)
    else $error("read not answered after two cycles");
  a_read_cause: assert property (host_rd_valid |-> $past(rd_go, 2))
    else $error("read valid without a read");
  a_unmapped_zero: assert property (rd_go && host_addr_load && unmapped |-> ##2 host_rdata == 40'h0000000000)
    else $error("unmapped read returned data");
  a_param_pad: assert property (rd_go && host_addr_load && host_addr <= 16'h01ff |-> ##2 host_rdata[39:32] == 8'h00)
    else $error("parameter read not padded");
  a_frame_busy: assert property (frame_start |=> core_busy)
    else $error("frame did not start the core");
  a_idle_wait: assert property (!core_busy && !frame_start |=> !core_busy)
    else $error("core woke without a frame");
  a_stream_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample) && $stable(out_chan))
    else $error("stream word changed before acceptance");
  a_frame_budget: assert property (run_r <= RUN_MAX)
    else $error("core ran past its frame budget");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> !out_valid && !core_busy && !host_rd_valid)
    else $error("outputs active in reset");
  cover property (out_valid && out_ready);
  cover property (out_valid && !out_ready ##1 out_valid && !out_ready);
  cover property ($fell(core_busy));
endmodule : dsp_core_props
`default_nettype wire

// ===== test/audio_sink.sv
// output stream consumer standing in for the serial output port
`default_nettype none
module audio_sink (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // mode
  input  wire logic        hold,
  input  wire logic        slow,
  // stream
  input  wire logic        out_valid,
  input  wire logic        out_chan,
  input  wire logic [23:0] out_sample,
  output logic             out_ready,
  // accepted words
  output logic             got,
  output logic      [24:0] got_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_r;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      toggle_r  <= 1'b0;
      out_ready <= 1'b0;
      got       <= 1'b0;
      got_word  <= 25'h0000000;
    end
    else
    begin
      toggle_r  <= !toggle_r;
      // slow mode drops ready every other cycle
      out_ready <= !hold && (!slow || toggle_r);
      got       <= out_valid && out_ready;
      got_word  <= {out_chan, out_sample};
    end
  end
endmodule : audio_sink
`default_nettype wire

// ===== test/tb_audio_dsp_core_with_memories.sv
// self-checking bench for the audio processing core
`default_nettype none
module tb_audio_dsp_core_with_memories;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic        frame_start;
  logic [23:0] audio_in_l;
  logic [23:0] audio_in_r;
  logic        host_wr_en;
  logic        host_rd_en;
  logic        host_addr_load;
  logic [15:0] host_addr;
  logic [39:0] host_wdata;
  logic [39:0] host_rdata;
  logic        host_rd_valid;
  logic        out_valid;
  logic        out_ready;
  logic        out_chan;
  logic [23:0] out_sample;
  logic        core_busy;
  logic        hold;
  logic        slow;
  logic        got;
  logic [24:0] got_word;
  logic [39:0] rd_q[$];
  logic [24:0] smp_q[$];
  logic [39:0] prog[0:9];
  logic [31:0] seed;
  int          err_count;
  int          samples_checked;
  dsp_core dut_u (.clk(clk), .rst(rst), .frame_start(frame_start), .audio_in_l(audio_in_l),
    .audio_in_r(audio_in_r), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
    .host_addr_load(host_addr_load), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rd_valid(host_rd_valid), .out_valid(out_valid),
    .out_ready(out_ready), .out_chan(out_chan), .out_sample(out_sample), .core_busy(core_busy));
  audio_sink sink_u (.clk(clk), .rst(rst), .hold(hold), .slow(slow), .out_valid(out_valid),
    .out_chan(out_chan), .out_sample(out_sample), .out_ready(out_ready), .got(got), .got_word(got_word));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  function automatic logic [23:0] clip(input logic signed [27:0] v);
    if (v > 28'sh07fffff)
      return 24'h7fffff;
    if (v < 28'shf800000)
      return 24'h800000;
    return v[23:0];
  endfunction : clip
  function automatic logic [39:0] ins(input logic [3:0] op, input logic [1:0] acc, input logic [3:0] src,
                                      input logic [8:0] da, input logic [8:0] pa, input logic [8:0] lo);
    return {op, acc, src, da, pa, 3'h0, lo};
  endfunction : ins
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic host(input logic wr, input logic rd, input logic ld, input logic [15:0] a, input logic [39:0] d);
    @(posedge clk);
    host_wr_en     <= wr;
    host_rd_en     <= rd;
    host_addr_load <= ld;
    host_addr      <= a;
    host_wdata     <= d;
    if (rd && !wr)
      rd_q.push_back(d);
  endtask : host
  task automatic wait_idle(input int n, input logic must);
    int i;
    i = 0;
    repeat (2) @(posedge clk);
    while (core_busy !== 1'b0 && i < n)
    begin
      @(posedge clk);
      i++;
    end
    if (must && i >= n)
    begin
      err_count++;
      $display("unexpected at %0t: core stuck busy", $time);
      complete_run();
    end
  endtask : wait_idle
  task automatic drain(input string name);
    int i;
    host(1'b0, 1'b0, 1'b0, 16'h0000, 40'h0000000000);
    for (i = 0; i < 400 && (rd_q.size() > 0 || smp_q.size() > 0); i++)
      @(posedge clk);
    if (i >= 400)
    begin
      err_count++;
      $display("unexpected at %0t: results missing", $time);
      complete_run();
    end
    $display("%s done", name);
  endtask : drain
  task automatic frame(input int rs);
    logic signed [27:0] lx;
    logic signed [27:0] rx;
    seed = xorshift(seed);
    lx = {{4{seed[23]}}, seed[23:0]};
    seed = xorshift(seed);
    rx = {{4{seed[23]}}, seed[23:0]};
    @(posedge clk);
    frame_start <= 1'b1;
    audio_in_l  <= lx[23:0];
    audio_in_r  <= rx[23:0];
    smp_q.push_back({1'b0, clip(lx)});
    smp_q.push_back({1'b1, clip(rx >>> rs)});
    smp_q.push_back({1'b0, clip(lx <<< 1)});
    @(posedge clk);
    frame_start <= 1'b0;
  endtask : frame
  always @(posedge clk)
  begin
    if (host_rd_valid === 1'b1)
      check(host_rdata, rd_q.pop_front());
    if (got === 1'b1)
      check({15'h0000, got_word}, {15'h0000, smp_q.pop_front()});
  end
  initial
  begin
    rst = 1'b0;
    frame_start = 1'b0;
    audio_in_l = 24'h000000;
    audio_in_r = 24'h000000;
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_addr_load = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 40'h0000000000;
    hold = 1'b0;
    slow = 1'b0;
    err_count = 0;
    samples_checked = 0;
    seed = 32'h0f5f56ee;
    prog[0] = ins(dsp_pkg::OP_MUL, 2'h0, {dsp_pkg::SRC_IN, dsp_pkg::SRC_ROM}, 9'h000, 9'h001, 9'h000);
    prog[1] = ins(dsp_pkg::OP_OUT, 2'h0, 4'h0, 9'h000, 9'h000, 9'h000);
    prog[2] = ins(dsp_pkg::OP_MUL, 2'h1, {dsp_pkg::SRC_IN, dsp_pkg::SRC_RAM}, 9'h001, 9'h008, 9'h000);
    prog[3] = ins(dsp_pkg::OP_OUT, 2'h1, 4'h0, 9'h000, 9'h000, 9'h001);
    // 0.5 once, then three passes adding 0.5 each: doubles the left input
    prog[4] = ins(dsp_pkg::OP_MUL, 2'h2, {dsp_pkg::SRC_IN, dsp_pkg::SRC_ROM}, 9'h000, 9'h002, 9'h000);
    prog[5] = ins(dsp_pkg::OP_LDC, 2'h3, 4'hf, 9'h000, 9'h000, 9'h002);
    prog[6] = ins(dsp_pkg::OP_MAC, 2'h2, {dsp_pkg::SRC_IN, dsp_pkg::SRC_ROM}, 9'h000, 9'h002, 9'h000);
    prog[7] = ins(dsp_pkg::OP_JNZ, 2'h3, 4'hf, 9'h000, 9'h000, 9'h006);
    prog[8] = ins(dsp_pkg::OP_OUT, 2'h2, 4'h0, 9'h000, 9'h000, 9'h000);
    prog[9] = ins(dsp_pkg::OP_JTS, 2'h3, 4'h0, 9'h000, 9'h000, 9'h000);
    #5 rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // ----------------------------------------
    // host memory access
    // ----------------------------------------
    for (int k = 0; k < 10; k++)
      host(1'b1, 1'b0, k == 0, 16'h0400, prog[k]);
    for (int k = 0; k < 10; k++)
      host(1'b0, 1'b1, k == 0, 16'h0400, prog[k]);
    host(1'b1, 1'b0, 1'b1, 16'h0008, 40'h0000400000);
    host(1'b1, 1'b0, 1'b1, 16'h01fe, 40'h000fedcba9);
    // second word lands on the auto address, the third in the hole
    host(1'b1, 1'b0, 1'b0, 16'h0000, 40'h000abcdef0);
    host(1'b1, 1'b0, 1'b0, 16'h0000, 40'hff12345678);
    host(1'b0, 1'b1, 1'b1, 16'h01fe, 40'h000fedcba9);
    host(1'b0, 1'b1, 1'b0, 16'h0000, 40'h000abcdef0);
    host(1'b0, 1'b1, 1'b0, 16'h0200, 40'h0000000000);
    host(1'b0, 1'b1, 1'b1, 16'h0600, 40'h0000000000);
    host(1'b1, 1'b1, 1'b1, 16'h0008, 40'h0000400000);
    host(1'b0, 1'b1, 1'b1, 16'h0008, 40'h0000400000);
    drain("memory");
    // ----------------------------------------
    // frames, prompt then slow consumer
    // ----------------------------------------
    for (int k = 0; k < 5; k++)
    begin
      slow <= k > 2;
      frame(1);
      wait_idle(100, 1'b1);
    end
    drain("frames");
    slow <= 1'b0;
    hold <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      frame(1);
      wait_idle(100, k < 2);
    end
    // fifo depth may hold the third frame, so push once more
    if (core_busy !== 1'b1)
    begin
      frame(1);
      repeat (60) @(posedge clk);
    end
    check({39'h0, core_busy}, 40'h0000000001);
    hold <= 1'b0;
    wait_idle(200, 1'b1);
    drain("stall");
    // ----------------------------------------
    // safeload of one parameter
    // ----------------------------------------
    host(1'b1, 1'b0, 1'b1, 16'h0001, 40'h0000200000);
    host(1'b1, 1'b0, 1'b1, 16'h0006, 40'h0000000007);
    host(1'b1, 1'b0, 1'b1, 16'h0007, 40'h0000000001);
    host(1'b0, 1'b0, 1'b0, 16'h0000, 40'h0000000000);
    frame(2);
    wait_idle(100, 1'b1);
    host(1'b0, 1'b1, 1'b1, 16'h0008, 40'h0000200000);
    drain("safeload");
    complete_run();
  end
endmodule : tb_audio_dsp_core_with_memories
bind dsp_core dsp_core_props chk_u (.clk(clk), .rst(rst), .frame_start(frame_start),
  .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_addr_load(host_addr_load),
  .host_addr(host_addr), .host_rdata(host_rdata), .host_rd_valid(host_rd_valid),
  .out_valid(out_valid), .out_ready(out_ready), .out_chan(out_chan), .out_sample(out_sample),
  .core_busy(core_busy));
`default_nettype wire
